// ### hdl/rmp_pkg.sv
package rmp_pkg;
    // ****************************************
    // Region and field layout
    // ****************************************
    localparam int NUM_REGIONS = 8;           // Protection regions
    localparam int NUM_SUBREG = 16;           // Subregions per region
    localparam int BASE_LSB = 12;             // Base address low bit
    localparam int VALID_BIT = 0;             // Valid flag position
    localparam int SIZE_LSB = 1;              // Size code low bit
    localparam int SIZE_MSB = 5;              // Size code high bit
    localparam int AP_WIDTH = 4;              // Permission code width
    localparam int CTRL_EN_BIT = 0;           // Enable bit position
    localparam logic [4:0] SIZE_MIN = 5'h0B;  // Smallest legal size code (4 KB)

    // ****************************************
    // System register select codes
    // ****************************************
    // Region registers: code = group base + region index
    localparam logic [4:0] SEL_BASE_SIZE = 5'h00;  // region_base_size 0..7
    localparam logic [4:0] SEL_SUBSEL = 5'h08;     // region_subregion_select 0..7
    localparam logic [4:0] SEL_CACHE_A = 5'h10;    // cacheable_flags_a
    localparam logic [4:0] SEL_CACHE_B = 5'h11;    // cacheable_flags_b
    localparam logic [4:0] SEL_BUF_A = 5'h12;      // bufferable_flags_a
    localparam logic [4:0] SEL_BUF_B = 5'h13;      // bufferable_flags_b
    localparam logic [4:0] SEL_PERM_A = 5'h14;     // permission_table_a
    localparam logic [4:0] SEL_PERM_B = 5'h15;     // permission_table_b
    localparam logic [4:0] SEL_CTRL = 5'h16;       // protection_control

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [31:0] RST_ZERO = 32'h0000_0000;  // All registers clear

    // ****************************************
    // Check result codes
    // ****************************************
    typedef enum logic [1:0] {
        RMP_OK,
        RMP_PROT,
        RMP_MISS,
        RMP_MULTI
    } rmp_res_t;
endpackage

// ### hdl/rmp_region_protect.sv
`timescale 1ns/1ns
module rmp_region_protect import rmp_pkg::*; #(
    parameter bit HAS_ATTR = 1'b1  // Implement cache/buffer flag registers
) (
    input wire logic I_CLK_SYS,
    input wire logic I_RESET,
    input wire logic i_SR_WR,
    input wire logic i_SR_RD,
    input wire logic [4:0] i_SR_SEL,
    input wire logic [31:0] i_SR_WDATA,
    output logic [31:0] o_SR_RDATA,
    input wire logic i_IF_REQ,
    input wire logic [31:0] i_IF_ADDR,
    input wire logic [31:0] i_IF_PC,
    input wire logic i_IF_PRIV,
    input wire logic i_D_REQ,
    input wire logic [31:0] i_D_ADDR,
    input wire logic i_D_WRITE,
    input wire logic [31:0] i_D_PC,
    input wire logic i_D_PRIV,
    output logic o_IF_DONE,
    output logic o_IF_PROT,
    output logic o_IF_MISS,
    output logic o_IF_MULTI,
    output logic [31:0] o_IF_FAIL_PC,
    output logic o_D_DONE,
    output logic o_D_PROT,
    output logic o_D_MISS,
    output logic o_D_MULTI,
    output logic o_D_CACHEABLE,
    output logic o_D_BUFFERABLE,
    output logic [31:0] o_D_FAIL_PC
);
    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [NUM_REGIONS-1:0][19:0] base;        // Base bits 31:12
        logic [NUM_REGIONS-1:0][4:0] size;         // Size codes
        logic [NUM_REGIONS-1:0] valid;             // Region valid
        logic [NUM_REGIONS-1:0][15:0] subsel;      // Subregion selects
        logic [NUM_REGIONS-1:0] cache_a;           // Cacheable, table A side
        logic [NUM_REGIONS-1:0] cache_b;           // Cacheable, table B side
        logic [NUM_REGIONS-1:0] buf_a;             // Bufferable, table A side
        logic [NUM_REGIONS-1:0] buf_b;             // Bufferable, table B side
        logic [NUM_REGIONS-1:0][3:0] perm_a;       // Permission table A
        logic [NUM_REGIONS-1:0][3:0] perm_b;       // Permission table B
        logic enable;                              // Checking enabled
        logic [31:0] rdata;                        // Read data
        logic if_done, if_prot, if_miss, if_multi; // Fetch answer
        logic [31:0] if_pc;                        // Fetch failing address
        logic d_done, d_prot, d_miss, d_multi;     // Data answer
        logic d_cache, d_buf;                      // Data attributes
        logic [31:0] d_pc;                         // Data failing address
    } rmp_state_t;

    rmp_state_t st_q;
    rmp_state_t st_d;

    // Combined check result over all regions for one access port
    typedef struct packed {
        rmp_res_t res;  // Outcome
        logic cache;    // Cacheable attribute
        logic bufa;     // Bufferable attribute
    } rmp_chk_t;

    // ****************************************
    // Permission decode
    // ****************************************
    // Kind: 0 read, 1 write, 2 execute
    function automatic logic perm_ok(input logic [3:0] ap, input logic priv, input logic [1:0] kind);
        logic r, w, x;
        r = 1'b0;
        w = 1'b0;
        x = 1'b0;
        case (ap)
            4'h0: begin r = priv; end
            4'h1: begin r = priv; x = priv; end
            4'h2: begin r = priv; w = priv; end
            4'h3: begin r = priv; w = priv; x = priv; end
            4'h4: begin r = 1'b1; end
            4'h5: begin r = 1'b1; x = 1'b1; end
            4'h6: begin r = 1'b1; w = 1'b1; end
            4'h7: begin r = 1'b1; w = 1'b1; x = 1'b1; end
            4'h8: begin r = 1'b1; w = priv; end
            4'h9: begin r = 1'b1; w = priv; x = !priv; end
            // 1010 and undefined codes deny everything
            default: begin r = 1'b0; end
        endcase
        case (kind)
            2'd0: perm_ok = r;
            2'd1: perm_ok = w;
            default: perm_ok = x;
        endcase
    endfunction

    // ****************************************
    // Region match and check
    // ****************************************
    // Sizes below 4 KB are undefined; they are treated as 4 KB here
    function automatic rmp_chk_t check(input rmp_state_t s, input logic [31:0] addr,
                                       input logic priv, input logic [1:0] kind);
        logic [NUM_REGIONS-1:0] hit;
        logic [31:0] mask;
        logic [4:0] sc;
        logic [3:0] sub;
        logic sel;
        logic [3:0] ap;
        logic ok;
        int cnt;
        check.res = RMP_OK;
        check.cache = 1'b0;
        check.bufa = 1'b0;
        ok = 1'b1;
        cnt = 0;
        for (int i = 0; i < NUM_REGIONS; i++) begin
            sc = (s.size[i] < SIZE_MIN) ? SIZE_MIN : s.size[i];
            // Region spans 2^(code+1) bytes
            mask = (sc == 5'h1F) ? 32'h0000_0000 : (32'hFFFF_FFFF << (sc + 5'h01));
            // Low 12 base bits read as zero
            hit[i] = s.valid[i] && ((addr & mask) == ({s.base[i], 12'h000} & mask));
            sub = 4'((addr >> (sc - 5'h03)) & 32'h0000_000F);
            if (hit[i]) begin
                cnt = cnt + 1;
                sel = s.subsel[i][sub];
                ap = sel ? s.perm_b[i] : s.perm_a[i];
                ok = perm_ok(ap, priv, kind);
                check.cache = sel ? s.cache_b[i] : s.cache_a[i];
                check.bufa = sel ? s.buf_b[i] : s.buf_a[i];
            end
        end
        if (cnt > 1) begin
            check.res = RMP_MULTI;
        end else if (cnt == 0) begin
            check.res = RMP_MISS;
        end else if (!ok) begin
            check.res = RMP_PROT;
        end
    endfunction

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        rmp_chk_t fc;
        rmp_chk_t dc;
        fc = check(st_q, i_IF_ADDR, i_IF_PRIV, 2'd2);
        dc = check(st_q, i_D_ADDR, i_D_PRIV, i_D_WRITE ? 2'd1 : 2'd0);
        st_d = st_q;
        // System register writes from the core's move instruction
        if (i_SR_WR) begin
            if (i_SR_SEL < SEL_SUBSEL) begin
                st_d.base[i_SR_SEL[2:0]] = i_SR_WDATA[31:BASE_LSB];
                st_d.size[i_SR_SEL[2:0]] = i_SR_WDATA[SIZE_MSB:SIZE_LSB];
                st_d.valid[i_SR_SEL[2:0]] = i_SR_WDATA[VALID_BIT];
            end else if (i_SR_SEL < SEL_CACHE_A) begin
                st_d.subsel[i_SR_SEL[2:0]] = i_SR_WDATA[NUM_SUBREG-1:0];
            end else begin
                case (i_SR_SEL)
                    SEL_CACHE_A: if (HAS_ATTR) st_d.cache_a = i_SR_WDATA[7:0];
                    SEL_CACHE_B: if (HAS_ATTR) st_d.cache_b = i_SR_WDATA[7:0];
                    SEL_BUF_A: if (HAS_ATTR) st_d.buf_a = i_SR_WDATA[7:0];
                    SEL_BUF_B: if (HAS_ATTR) st_d.buf_b = i_SR_WDATA[7:0];
                    SEL_PERM_A: st_d.perm_a = i_SR_WDATA;
                    SEL_PERM_B: st_d.perm_b = i_SR_WDATA;
                    SEL_CTRL: st_d.enable = i_SR_WDATA[CTRL_EN_BIT];
                    default: ;
                endcase
            end
        end
        // Read path; unmapped codes read zero
        st_d.rdata = RST_ZERO;
        if (i_SR_RD) begin
            if (i_SR_SEL < SEL_SUBSEL) begin
                st_d.rdata = {st_q.base[i_SR_SEL[2:0]], 6'h00, st_q.size[i_SR_SEL[2:0]],
                              st_q.valid[i_SR_SEL[2:0]]};
            end else if (i_SR_SEL < SEL_CACHE_A) begin
                st_d.rdata = {16'h0000, st_q.subsel[i_SR_SEL[2:0]]};
            end else begin
                case (i_SR_SEL)
                    SEL_CACHE_A: st_d.rdata = {24'h000000, st_q.cache_a};
                    SEL_CACHE_B: st_d.rdata = {24'h000000, st_q.cache_b};
                    SEL_BUF_A: st_d.rdata = {24'h000000, st_q.buf_a};
                    SEL_BUF_B: st_d.rdata = {24'h000000, st_q.buf_b};
                    SEL_PERM_A: st_d.rdata = st_q.perm_a;
                    SEL_PERM_B: st_d.rdata = st_q.perm_b;
                    SEL_CTRL: st_d.rdata = {31'h00000000, st_q.enable};
                    default: st_d.rdata = RST_ZERO;
                endcase
            end
        end
        // Fetch answer one cycle after request
        st_d.if_done = i_IF_REQ;
        st_d.if_prot = i_IF_REQ && st_q.enable && (fc.res == RMP_PROT);
        st_d.if_miss = i_IF_REQ && st_q.enable && (fc.res == RMP_MISS);
        st_d.if_multi = i_IF_REQ && st_q.enable && (fc.res == RMP_MULTI);
        st_d.if_pc = i_IF_REQ ? i_IF_PC : st_q.if_pc;
        // Data answer; attributes forced off while disabled
        st_d.d_done = i_D_REQ;
        st_d.d_prot = i_D_REQ && st_q.enable && (dc.res == RMP_PROT);
        st_d.d_miss = i_D_REQ && st_q.enable && (dc.res == RMP_MISS);
        st_d.d_multi = i_D_REQ && st_q.enable && (dc.res == RMP_MULTI);
        st_d.d_cache = i_D_REQ && st_q.enable && (dc.res == RMP_OK) && dc.cache;
        st_d.d_buf = i_D_REQ && st_q.enable && (dc.res == RMP_OK) && dc.bufa;
        st_d.d_pc = i_D_REQ ? i_D_PC : st_q.d_pc;
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge I_CLK_SYS) begin
        if (I_RESET) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign o_SR_RDATA = st_q.rdata;
    assign o_IF_DONE = st_q.if_done;
    assign o_IF_PROT = st_q.if_prot;
    assign o_IF_MISS = st_q.if_miss;
    assign o_IF_MULTI = st_q.if_multi;
    assign o_IF_FAIL_PC = st_q.if_pc;
    assign o_D_DONE = st_q.d_done;
    assign o_D_PROT = st_q.d_prot;
    assign o_D_MISS = st_q.d_miss;
    assign o_D_MULTI = st_q.d_multi;
    assign o_D_CACHEABLE = st_q.d_cache;
    assign o_D_BUFFERABLE = st_q.d_buf;
    assign o_D_FAIL_PC = st_q.d_pc;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (I_RESET);

    AST_NO_EXC_DISABLED: assert property (!st_q.enable && !i_SR_WR |=> !o_IF_PROT && !o_D_PROT && !o_IF_MISS)
        else $error("exception while disabled");
    AST_DIS_ATTR: assert property (!st_q.enable |=> !o_D_CACHEABLE && !o_D_BUFFERABLE)
        else $error("attribute while disabled");
    AST_IF_MISS: assert property (i_IF_REQ && st_q.enable && st_q.valid == '0 |=> o_IF_MISS)
        else $error("fetch miss not raised");
    AST_D_MISS: assert property (i_D_REQ && st_q.enable && st_q.valid == '0 |=> o_D_MISS)
        else $error("data miss not raised");
    AST_ONE_EXC: assert property (o_D_DONE |-> $onehot0({o_D_PROT, o_D_MISS, o_D_MULTI}))
        else $error("data exceptions overlap");
    AST_IF_PC: assert property (i_IF_REQ |=> o_IF_FAIL_PC == $past(i_IF_PC))
        else $error("fetch address not held");
    AST_D_PC: assert property (i_D_REQ |=> o_D_FAIL_PC == $past(i_D_PC))
        else $error("data address not held");
    AST_CTRL_RB: assert property (i_SR_WR && i_SR_SEL == SEL_CTRL ##1 i_SR_RD && i_SR_SEL == SEL_CTRL && !i_SR_WR
                                  |=> o_SR_RDATA[0] == $past(i_SR_WDATA[0], 2))
        else $error("control readback wrong");
    AST_DONE: assert property (o_IF_PROT || o_IF_MISS || o_IF_MULTI |-> o_IF_DONE)
        else $error("fetch fault without request");

    // ****************************************
    // Answer timing and register cross-checks
    // ****************************************
    // The core relies on a fixed one-cycle answer, so no request may go unanswered
    // Every fetch request is answered on the next cycle
    AST_IF_ANSWER: assert property (i_IF_REQ |=> o_IF_DONE)
        else $error("fetch answer missing");
    // Every data request is answered on the next cycle
    AST_D_ANSWER: assert property (i_D_REQ |=> o_D_DONE)
        else $error("data answer missing");
    // No fetch answer without a request
    AST_IF_IDLE: assert property (!i_IF_REQ |=> !o_IF_DONE && !o_IF_PROT)
        else $error("fetch answer without request");
    // No data answer or cacheable attribute without a request
    AST_D_IDLE: assert property (!i_D_REQ |=> !o_D_DONE && !o_D_CACHEABLE)
        else $error("data answer without request");
    // Data fault bits only ride with an answer
    AST_D_FAULT_REQ: assert property (o_D_PROT || o_D_MISS || o_D_MULTI |-> o_D_DONE)
        else $error("data fault without request");
    // One fetch fault kind at a time
    AST_IF_ONE_EXC: assert property (o_IF_DONE |-> $onehot0({o_IF_PROT, o_IF_MISS, o_IF_MULTI}))
        else $error("fetch exceptions overlap");
    // Attributes never accompany a faulting access
    AST_ATTR_NO_FAULT: assert property (o_D_CACHEABLE || o_D_BUFFERABLE |-> o_D_DONE && !o_D_PROT && !o_D_MISS
                                        && !o_D_MULTI)
        else $error("attribute on faulting access");
    // Remaining fault kinds stay quiet while disabled
    AST_DIS_NO_FAULT: assert property (!st_q.enable && !i_SR_WR |=> !o_IF_MULTI && !o_D_MISS && !o_D_MULTI)
        else $error("fault while disabled");
    // Read data falls back to zero after an idle cycle
    AST_RD_IDLE: assert property (!i_SR_RD |=> o_SR_RDATA == RST_ZERO)
        else $error("read data not cleared");
    // Without the option the flag registers stay clear
    AST_NO_ATTR_OPT: assert property (!HAS_ATTR |-> st_q.cache_a == '0 && st_q.cache_b == '0 && st_q.buf_a == '0
                                      && st_q.buf_b == '0)
        else $error("flag register present");
    // Failing fetch address holds between requests
    AST_IF_PC_HOLD: assert property (!i_IF_REQ |=> $stable(o_IF_FAIL_PC))
        else $error("fetch address drifted");
    // Failing data address holds between requests
    AST_D_PC_HOLD: assert property (!i_D_REQ |=> $stable(o_D_FAIL_PC))
        else $error("data address drifted");
    // Enable follows the control write
    AST_EN_WRITE: assert property (i_SR_WR && i_SR_SEL == SEL_CTRL |=> st_q.enable == $past(i_SR_WDATA[CTRL_EN_BIT]))
        else $error("enable write lost");
    // Valid flag follows the region write
    AST_VALID_WRITE: assert property (i_SR_WR && i_SR_SEL < SEL_SUBSEL
                                      |=> st_q.valid[$past(i_SR_SEL[2:0])] == $past(i_SR_WDATA[VALID_BIT]))
        else $error("valid write lost");
    // Subregion selects follow their write
    AST_SUBSEL_WRITE: assert property (i_SR_WR && i_SR_SEL >= SEL_SUBSEL && i_SR_SEL < SEL_CACHE_A
                                       |=> st_q.subsel[$past(i_SR_SEL[2:0])] == $past(i_SR_WDATA[15:0]))
        else $error("select write lost");
    // Table A follows its write
    AST_PERM_A_WRITE: assert property (i_SR_WR && i_SR_SEL == SEL_PERM_A |=> st_q.perm_a == $past(i_SR_WDATA))
        else $error("table A write lost");
    // Table B follows its write
    AST_PERM_B_WRITE: assert property (i_SR_WR && i_SR_SEL == SEL_PERM_B |=> st_q.perm_b == $past(i_SR_WDATA))
        else $error("table B write lost");

    COV_IF_PROT: cover property (o_IF_PROT);
    COV_D_PROT: cover property (o_D_PROT);
    COV_MULTI: cover property (o_D_MULTI);
    COV_CACHE: cover property (o_D_CACHEABLE);
    COV_IF_MISS: cover property (o_IF_MISS);
endmodule

// ### test/rmp_core_model.sv
`timescale 1ns/1ns
// ****************************************
// Core fetch and data request side
// ****************************************
module rmp_core_model import rmp_pkg::*; (
    input wire logic I_CLK_SYS,
    input wire logic i_go_if,
    input wire logic i_go_d,
    input wire logic [31:0] i_addr_if,
    input wire logic [31:0] i_addr_d,
    output logic o_req_if,
    output logic o_req_d,
    output logic [31:0] o_addr_if,
    output logic [31:0] o_addr_d
);
    logic [31:0] last_if_q = 32'h0000_0000; // Last fetch address on the bus
    logic [31:0] last_d_q = 32'h0000_0000;  // Last data address on the bus
    // Remember each bus value for the idle scramble
    always_ff @(posedge I_CLK_SYS) begin
        last_if_q <= o_addr_if;
        last_d_q <= o_addr_d;
    end
    // Idle buses flip each cycle, so a stale address is never mistaken for a live one
    assign o_req_if = i_go_if;
    assign o_req_d = i_go_d;
    assign o_addr_if = i_go_if ? i_addr_if : ~last_if_q;
    assign o_addr_d = i_go_d ? i_addr_d : ~last_d_q;
endmodule

// ### test/region_memory_protection_tb.sv
`timescale 1ns/1ns
module region_memory_protection_tb import rmp_pkg::*;;
    // ****************************************
    // Stimulus and observed signals
    // ****************************************
    logic clk, rst = 1'b1, wr = 1'b0, rd = 1'b0, go_if = 1'b0, go_d = 1'b0, priv = 1'b0, wrt = 1'b0;
    logic [4:0] sel = 5'h00;
    logic [31:0] wd = 32'h0, a_if = 32'h0, a_d = 32'h0, pc_d = 32'h0, ai, ad, rdata, fpc_if, fpc_d;
    logic req_if, req_d, if_done, if_prot, if_miss, if_multi;
    logic d_done, d_prot, d_miss, d_multi, d_c, d_b;
    logic [31:0] mreg [32];          // Register image, indexed by select code
    logic [31:0] lpc_if = 32'h0, lpc_d = 32'h0; // Held failing addresses
    int err_count = 0, num_checks = 0, cyc = 0;

    rmp_core_model core (.I_CLK_SYS(clk), .i_go_if(go_if), .i_go_d(go_d), .i_addr_if(a_if),
        .i_addr_d(a_d), .o_req_if(req_if), .o_req_d(req_d), .o_addr_if(ai), .o_addr_d(ad));
    rmp_region_protect DUT (.I_CLK_SYS(clk), .I_RESET(rst), .i_SR_WR(wr), .i_SR_RD(rd), .i_SR_SEL(sel),
        .i_SR_WDATA(wd), .o_SR_RDATA(rdata), .i_IF_REQ(req_if), .i_IF_ADDR(ai), .i_IF_PC(ai),
        .i_IF_PRIV(priv), .i_D_REQ(req_d), .i_D_ADDR(ad), .i_D_WRITE(wrt), .i_D_PC(pc_d),
        .i_D_PRIV(priv), .o_IF_DONE(if_done), .o_IF_PROT(if_prot), .o_IF_MISS(if_miss),
        .o_IF_MULTI(if_multi), .o_IF_FAIL_PC(fpc_if), .o_D_DONE(d_done), .o_D_PROT(d_prot),
        .o_D_MISS(d_miss), .o_D_MULTI(d_multi), .o_D_CACHEABLE(d_c), .o_D_BUFFERABLE(d_b),
        .o_D_FAIL_PC(fpc_d));

    // ****************************************
    // Clock and watchdog
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Whole run needs about 1350 cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            complete_run();
        end
    end

    // ****************************************
    // Reference model
    // ****************************************
    // Bits that each register really keeps
    function automatic logic [31:0] msk(input logic [4:0] s);
        if (s < 5'h08) return 32'hFFFFF03F;
        if (s < 5'h10) return 32'h0000FFFF;
        if (s < 5'h14) return 32'h000000FF;
        if (s < 5'h16) return 32'hFFFFFFFF;
        return (s == 5'h16) ? 32'h00000001 : 32'h00000000;
    endfunction
    // Access kinds: 0 read, 1 write, 2 execute
    function automatic logic perm(input logic [3:0] ap, input logic pv, input logic [1:0] k);
        if (ap < 4'h8) return (pv | ap[2]) && (k == 2'h0 || (k == 2'h1 && ap[1]) || (k == 2'h2 && ap[0]));
        if (ap == 4'h8) return k == 2'h0 || (pv && k == 2'h1);
        if (ap == 4'h9) return pv ? k != 2'h2 : k != 2'h1;
        return 1'b0;
    endfunction
    // Result packed as prot, miss, multi, cacheable, bufferable
    function automatic logic [4:0] model(input logic [31:0] a, input logic pv, input logic [1:0] k);
        int hits;
        int sz;
        logic bs;
        logic [4:0] r;
        logic [31:0] base;
        hits = 0;
        r = 5'h00;
        if (!mreg[22][0]) return 5'h00;
        for (int n = 0; n < 8; n++) begin
            sz = mreg[n][5:1] < 5'h0B ? 11 : mreg[n][5:1];
            base = {mreg[n][31:12], 12'h000};
            if (mreg[n][0] && (a >> (sz + 1)) == (base >> (sz + 1))) begin
                hits++;
                bs = mreg[n + 8][(a >> (sz - 3)) & 15];
                r = {!perm(mreg[bs ? 21 : 20][4 * n +: 4], pv, k), 2'h0, mreg[bs ? 17 : 16][n],
                    mreg[bs ? 19 : 18][n]};
            end
        end
        if (hits > 1) return 5'h04;
        if (hits == 0) return 5'h08;
        return r[4] ? 5'h10 : r;
    endfunction
    // Mostly inside the low 8 MB where regions live
    function automatic logic [31:0] raddr();
        return ($urandom % 4 == 0) ? $urandom : {9'h000, 3'($urandom % 8), 20'($urandom)};
    endfunction

    // ****************************************
    // Shared tasks
    // ****************************************
    task check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One system register move; reads compare against the image
    task sr(input logic w, input logic [4:0] s, input logic [31:0] d);
        @(posedge clk);
        wr <= w;
        rd <= !w;
        sel <= s;
        wd <= d;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        #1;
        if (w) mreg[s] = d & msk(s);
        else check(rdata, mreg[s]);
    endtask
    // Back-to-back random fetch and data checks, answer one cycle later
    task traffic(input int n);
        logic gi, gd, pv, wt;
        logic [31:0] an, dn, pn;
        logic [3:0] eif;
        logic [5:0] ed;
        logic [4:0] r;
        eif = 4'h0;
        ed = 6'h00;
        for (int i = 0; i <= n; i++) begin
            @(posedge clk);
            gi = (i < n) && ($urandom % 4 != 0);
            gd = (i < n) && ($urandom % 4 != 0);
            pv = 1'($urandom);
            wt = 1'($urandom);
            an = raddr();
            dn = raddr();
            pn = $urandom;
            go_if <= gi;
            go_d <= gd;
            a_if <= an;
            a_d <= dn;
            priv <= pv;
            wrt <= wt;
            pc_d <= pn;
            #1;
            check({28'h0, if_done, if_prot, if_miss, if_multi}, {28'h0, eif});
            check(fpc_if, lpc_if);
            check({26'h0, d_done, d_prot, d_miss, d_multi, d_c, d_b}, {26'h0, ed});
            check(fpc_d, lpc_d);
            r = model(an, pv, 2'h2);
            eif = {gi, gi ? r[4:2] : 3'h0};
            r = model(dn, pv, {1'b0, wt});
            ed = gd ? {1'b1, r} : 6'h00;
            if (gi) lpc_if = an;
            if (gd) lpc_d = pn;
        end
    endtask
    task complete_run();
        $display("Checks %0d, mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        void'($urandom(32'hDAA1));
        for (int s = 0; s < 32; s++) mreg[s] = 32'h0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        for (int s = 0; s < 32; s++) sr(1'b0, 5'(s), 32'h0);
        $display("Test 1 reset values done");
        traffic(20);
        $display("Test 2 disabled traffic done");
        sr(1'b1, 5'h16, 32'h00000001);
        traffic(20);
        $display("Test 3 enabled miss done");
        // Bases on 1 MB slots keep sizes up to 1 MB aligned, and overlaps occur
        repeat (4) begin
            for (int n = 0; n < 8; n++) begin
                sr(1'b1, 5'(n), {9'h0, 3'($urandom % 8), 8'h0, 6'($urandom), 5'(11 + $urandom % 9),
                    1'($urandom % 4 != 0)});
                sr(1'b1, 5'(n + 8), $urandom);
            end
            for (int s = 16; s < 24; s++) sr(1'b1, 5'(s), (s == 22) ? 32'hFFFFFFFF : $urandom);
            for (int s = 0; s < 24; s++) sr(1'b0, 5'(s), 32'h0);
            traffic(200);
        end
        $display("Test 4 random regions done");
        sr(1'b1, 5'h16, 32'h00000000);
        traffic(30);
        $display("Test 5 disable done");
        complete_run();
    end
endmodule
